// >>> core/lane_defines.svh
`ifndef LANE_DEFINES_SVH
`define LANE_DEFINES_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define LANE_ADDR_CTRL    4'h0
`define LANE_ADDR_STATUS  4'h4
`define LANE_ADDR_DELAY   4'h8
`define LANE_ADDR_RXWORD  4'hc

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define LANE_CTRL_QUEUE_EN    0
`define LANE_CTRL_TX_MODE     1
`define LANE_CTRL_REVERSIBLE  2
`define LANE_STAT_EMPTY       0
`define LANE_STAT_FULL        1
`define LANE_STAT_OVERFLOW    2
`define LANE_STAT_RX_RESET    3
`define LANE_STAT_HS_ACTIVE   4

// ------------------------------------------------------------
// Reset values and counts
// ------------------------------------------------------------
`define LANE_CTRL_RESET       3'h0
`define LANE_DELAY_INIT       3'h0
`define LANE_SERDES_RATIO     8
`define LANE_DIV_LAST         3'h7
`define LANE_DIV_PRE_LAST     3'h6
`define LANE_DIV_RESET        3'h0
`define LANE_RESP_OKAY        2'h0
`define LANE_RESP_SLVERR      2'h2

`endif

// >>> core/lane_pkg.sv
package lane_pkg;

   // AXI4-Lite master to slave
   typedef struct packed {
      logic        awvalid;
      logic [31:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [31:0] araddr;
      logic        rready;
   } axil_req_type;

   // AXI4-Lite slave to master
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axil_rsp_type;

   // Lane configuration
   typedef struct packed {
      logic reversible;
      logic tx_mode;
      logic queue_en;
   } ctrl_type;

endpackage

// >>> core/lane_rx_queue.sv
`timescale 1ns/1ps
`default_nettype none

module lane_rx_queue #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             clear,
   input  wire logic             push_valid,
   input  wire logic [WIDTH-1:0] push_data,
   output logic                  push_ready,
   input  wire logic             pop_ready,
   output logic                  pop_valid,
   output logic [WIDTH-1:0]      pop_data,
   output logic                  empty,
   output logic                  full
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic [WIDTH-1:0] data_q, data_d;
   logic             do_push, do_pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign empty      = (cnt_q == '0);
   assign full       = (cnt_q == (AW+1)'(DEPTH));
   assign push_ready = !full;
   assign pop_valid  = !empty;
   assign pop_data   = data_q;
   assign do_push    = push_valid && !full;
   assign do_pop     = pop_ready && !empty;

   always_comb begin
      wr_d   = do_push ? bump(wr_q) : wr_q;
      rd_d   = do_pop ? bump(rd_q) : rd_q;
      data_d = do_pop ? mem_q[rd_q] : data_q;
      cnt_d  = cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
      if (clear) begin
         wr_d   = '0;
         rd_d   = '0;
         cnt_d  = '0;
         data_d = '0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_q   <= '0;
         rd_q   <= '0;
         cnt_q  <= '0;
         data_q <= '0;
      end else begin
         wr_q   <= wr_d;
         rd_q   <= rd_d;
         cnt_q  <= cnt_d;
         data_q <= data_d;
      end
   end

   always_ff @(posedge clk) begin
      if (do_push && !clear) begin
         mem_q[wr_q] <= push_data;
      end
   end

endmodule // lane_rx_queue

`default_nettype wire

// >>> core/dphy_lane_serdes_io.sv
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lane_defines.svh"

module dphy_lane_serdes_io #(
   parameter int DELAY_WIDTH = 3,
   parameter int QUEUE_DEPTH = 4
) (
   input  wire logic                CLOCK,
   input  wire logic                SYS_RST,
   input  wire lane_pkg::axil_req_type AXI_REQ,
   output lane_pkg::axil_rsp_type   AXI_RSP,
   input  wire logic                RX_RESET,
   input  wire logic                TX_RESET,
   input  wire logic                PAD_P_IN,
   input  wire logic                PAD_N_IN,
   output logic                     PAD_P_OUT,
   output logic                     PAD_P_OE,
   output logic                     PAD_N_OUT,
   output logic                     PAD_N_OE,
   output logic                     PAD_TERM_ENABLE,
   output logic [7:0]               HIGHSPEED_RX_WORD,
   output logic                     LOWPOWER_SENSE_POS,
   output logic                     LOWPOWER_SENSE_NEG,
   input  wire logic                LOWPOWER_DRIVE_POS,
   input  wire logic                LOWPOWER_DRIVE_NEG,
   input  wire logic                LOWPOWER_DRIVE_ENABLE_POS,
   input  wire logic                LOWPOWER_DRIVE_ENABLE_NEG,
   output logic                     QUEUE_EMPTY,
   input  wire logic                QUEUE_READ_ENABLE,
   output logic                     LANE_PARALLEL_CLOCK_OUT,
   output logic                     LANE_SERIAL_CLOCK_OUT,
   output logic                     CORE_TREE_CLOCK_OUT,
   input  wire logic                DIFF_BUFFER_ENABLE,
   input  wire logic                RX_TERMINATION_ENABLE,
   input  wire logic                DELAY_STEP_ENABLE,
   input  wire logic                DELAY_STEP_DIRECTION,
   input  wire logic                DELAY_COUNTER_CLEAR,
   input  wire logic [7:0]          HIGHSPEED_TX_WORD,
   input  wire logic                HIGHSPEED_DRIVE_ENABLE
);
   localparam int TAPS = 2 ** DELAY_WIDTH;

   // ------------------------------------------------------------
   // Clock divider
   // ------------------------------------------------------------
   logic [2:0] div_q, div_d;
   logic       strobe_q, strobe_d;
   logic       tree_q, tree_d;
   logic       serial_q;

   always_comb begin
      div_d    = div_q + 3'h1;
      strobe_d = (div_q == `LANE_DIV_PRE_LAST);
      tree_d   = div_d[2];
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         div_q    <= `LANE_DIV_RESET;
         strobe_q <= 1'b0;
         tree_q   <= 1'b0;
         serial_q <= 1'b0;
      end else begin
         div_q    <= div_d;
         strobe_q <= strobe_d;
         tree_q   <= tree_d;
         serial_q <= 1'b1;
      end
   end

   assign LANE_PARALLEL_CLOCK_OUT = strobe_q;
   assign LANE_SERIAL_CLOCK_OUT   = serial_q;
   assign CORE_TREE_CLOCK_OUT     = tree_q;

   // ------------------------------------------------------------
   // Configuration and receive reset
   // ------------------------------------------------------------
   lane_pkg::ctrl_type ctrl_q, ctrl_d;
   logic [1:0]         rxr_q, rxr_d;
   logic               rx_rst;

   always_comb begin
      rxr_d = rxr_q;
      if (ctrl_q.queue_en || strobe_q) begin
         rxr_d = {rxr_q[0], 1'b0};
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST or posedge RX_RESET) begin
      if (SYS_RST || RX_RESET) begin
         rxr_q <= 2'h3;
      end else begin
         rxr_q <= rxr_d;
      end
   end

   assign rx_rst = rxr_q[1];

   // ------------------------------------------------------------
   // Receive delay and deserializer
   // ------------------------------------------------------------
   logic [DELAY_WIDTH-1:0] dly_q, dly_d;
   logic [TAPS-1:0]        tap_q, tap_d;
   logic [7:0]             rsh_q, rsh_d;
   logic [7:0]             rword_q, rword_d;
   logic                   rbit, hs_rx, push;
   logic                   ovf_q, ovf_d;
   logic                   q_ready, q_full, q_valid;
   logic [7:0]             q_data;

   assign hs_rx = !ctrl_q.tx_mode && DIFF_BUFFER_ENABLE && !rx_rst;
   assign rbit  = tap_q[dly_q];
   assign push  = hs_rx && strobe_q && ctrl_q.queue_en;

   always_comb begin
      dly_d = dly_q;
      if (strobe_q) begin
         if (DELAY_COUNTER_CLEAR) begin
            dly_d = `LANE_DELAY_INIT;
         end else if (DELAY_STEP_ENABLE) begin
            if (DELAY_STEP_DIRECTION && dly_q != '1) begin
               dly_d = dly_q + 1'b1;
            end else if (!DELAY_STEP_DIRECTION && dly_q != '0) begin
               dly_d = dly_q - 1'b1;
            end
         end
      end
      tap_d   = {tap_q[TAPS-2:0], PAD_P_IN};
      rsh_d   = rsh_q;
      rword_d = rword_q;
      if (rx_rst) begin
         rsh_d   = '0;
         rword_d = '0;
      end else if (hs_rx) begin
         rsh_d = {rbit, rsh_q[7:1]};
         if (strobe_q) begin
            rword_d = {rbit, rsh_q[7:1]};
         end
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         dly_q   <= `LANE_DELAY_INIT;
         tap_q   <= '0;
         rsh_q   <= '0;
         rword_q <= '0;
      end else begin
         dly_q   <= dly_d;
         tap_q   <= tap_d;
         rsh_q   <= rsh_d;
         rword_q <= rword_d;
      end
   end

   // ------------------------------------------------------------
   // Optional receive queue
   // ------------------------------------------------------------
   lane_rx_queue #(
      .WIDTH (8),
      .DEPTH (QUEUE_DEPTH)
   ) u_queue (
      .clk        (CLOCK),
      .rst        (SYS_RST),
      .clear      (rx_rst),
      .push_valid (push),
      .push_data  ({rbit, rsh_q[7:1]}),
      .push_ready (q_ready),
      .pop_ready  (QUEUE_READ_ENABLE && ctrl_q.queue_en),
      .pop_valid  (q_valid),
      .pop_data   (q_data),
      .empty      (),
      .full       (q_full)
   );

   assign QUEUE_EMPTY       = ctrl_q.queue_en && !q_valid;
   assign HIGHSPEED_RX_WORD = ctrl_q.queue_en ? q_data : rword_q;

   // ------------------------------------------------------------
   // Transmit serializer and pads
   // ------------------------------------------------------------
   logic [7:0] tsh_q, tsh_d;

   always_comb begin
      tsh_d = {1'b0, tsh_q[7:1]};
      if (strobe_q) begin
         tsh_d = TX_RESET ? 8'h00 : HIGHSPEED_TX_WORD;
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         tsh_q <= '0;
      end else begin
         tsh_q <= tsh_d;
      end
   end

   always_comb begin
      PAD_P_OUT = LOWPOWER_DRIVE_POS;
      PAD_N_OUT = LOWPOWER_DRIVE_NEG;
      PAD_P_OE  = 1'b0;
      PAD_N_OE  = 1'b0;
      if (ctrl_q.tx_mode) begin
         if (HIGHSPEED_DRIVE_ENABLE) begin
            PAD_P_OUT = tsh_q[0];
            PAD_N_OUT = ~tsh_q[0];
            PAD_P_OE  = 1'b1;
            PAD_N_OE  = 1'b1;
         end else begin
            PAD_P_OE = LOWPOWER_DRIVE_ENABLE_POS;
            PAD_N_OE = LOWPOWER_DRIVE_ENABLE_NEG;
         end
      end else if (ctrl_q.reversible) begin
         PAD_P_OE = LOWPOWER_DRIVE_ENABLE_POS;
         PAD_N_OE = LOWPOWER_DRIVE_ENABLE_NEG;
      end
   end

   assign LOWPOWER_SENSE_POS = (!ctrl_q.tx_mode || ctrl_q.reversible) &&
                               PAD_P_IN;
   assign LOWPOWER_SENSE_NEG = (!ctrl_q.tx_mode || ctrl_q.reversible) &&
                               PAD_N_IN;
   assign PAD_TERM_ENABLE    = !ctrl_q.tx_mode && RX_TERMINATION_ENABLE;

   // ------------------------------------------------------------
   // Register slave
   // ------------------------------------------------------------
   logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
   logic [3:0]  waddr_q, waddr_d;
   logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
   logic        wbad_q, wbad_d, rbad_q, rbad_d;

   function automatic logic mapped(input logic [31:0] a);
      mapped = (a[31:4] == 28'h0) && (a[1:0] == 2'h0);
   endfunction

   always_comb begin
      aw_d    = aw_q;
      w_d     = w_q;
      b_d     = b_q;
      r_d     = r_q;
      waddr_d = waddr_q;
      wdata_d = wdata_q;
      wbad_d  = wbad_q;
      rbad_d  = rbad_q;
      rdata_d = rdata_q;
      ctrl_d  = ctrl_q;
      ovf_d   = ovf_q;
      if (!aw_q && !b_q && AXI_REQ.awvalid) begin
         aw_d    = 1'b1;
         waddr_d = AXI_REQ.awaddr[3:0];
         wbad_d  = !mapped(AXI_REQ.awaddr);
      end
      if (!w_q && !b_q && AXI_REQ.wvalid) begin
         w_d     = 1'b1;
         wdata_d = AXI_REQ.wdata;
      end
      if (aw_q && w_q) begin
         aw_d = 1'b0;
         w_d  = 1'b0;
         b_d  = 1'b1;
         if (!wbad_q && waddr_q == `LANE_ADDR_CTRL) begin
            ctrl_d = lane_pkg::ctrl_type'(wdata_q[2:0]);
         end
         if (!wbad_q && waddr_q == `LANE_ADDR_STATUS &&
             wdata_q[`LANE_STAT_OVERFLOW]) begin
            ovf_d = 1'b0;
         end
      end
      if (push && !q_ready) begin
         ovf_d = 1'b1;
      end
      if (b_q && AXI_REQ.bready) begin
         b_d = 1'b0;
      end
      if (r_q && AXI_REQ.rready) begin
         r_d = 1'b0;
      end else if (!r_q && AXI_REQ.arvalid) begin
         r_d     = 1'b1;
         rbad_d  = !mapped(AXI_REQ.araddr);
         rdata_d = '0;
         case (AXI_REQ.araddr[3:0])
            `LANE_ADDR_CTRL:   rdata_d[2:0] = ctrl_q;
            `LANE_ADDR_STATUS: rdata_d[4:0] = {hs_rx, rx_rst, ovf_q,
                                               q_full, QUEUE_EMPTY};
            `LANE_ADDR_DELAY:  rdata_d[DELAY_WIDTH-1:0] = dly_q;
            `LANE_ADDR_RXWORD: rdata_d[7:0] = rword_q;
            default:           rdata_d = '0;
         endcase
         if (rbad_d) begin
            rdata_d = '0;
         end
      end
   end

   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         aw_q    <= 1'b0;
         w_q     <= 1'b0;
         b_q     <= 1'b0;
         r_q     <= 1'b0;
         waddr_q <= 4'h0;
         wdata_q <= 32'h0000_0000;
         wbad_q  <= 1'b0;
         rbad_q  <= 1'b0;
         rdata_q <= 32'h0000_0000;
         ctrl_q  <= `LANE_CTRL_RESET;
         ovf_q   <= 1'b0;
      end else begin
         aw_q    <= aw_d;
         w_q     <= w_d;
         b_q     <= b_d;
         r_q     <= r_d;
         waddr_q <= waddr_d;
         wdata_q <= wdata_d;
         wbad_q  <= wbad_d;
         rbad_q  <= rbad_d;
         rdata_q <= rdata_d;
         ctrl_q  <= ctrl_d;
         ovf_q   <= ovf_d;
      end
   end

   always_comb begin
      AXI_RSP         = '0;
      AXI_RSP.awready = !aw_q && !b_q;
      AXI_RSP.wready  = !w_q && !b_q;
      AXI_RSP.bvalid  = b_q;
      AXI_RSP.bresp   = wbad_q ? `LANE_RESP_SLVERR : `LANE_RESP_OKAY;
      AXI_RSP.arready = !r_q;
      AXI_RSP.rvalid  = r_q;
      AXI_RSP.rdata   = rdata_q;
      AXI_RSP.rresp   = rbad_q ? `LANE_RESP_SLVERR : `LANE_RESP_OKAY;
   end

endmodule // dphy_lane_serdes_io

`default_nettype wire

// >>> verification/lane_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker for the lane
// ----------------------------------------
module lane_props (
   input wire logic                   CLOCK,
   input wire logic                   SYS_RST,
   input wire logic                   RX_RESET,
   input wire logic                   TX_RESET,
   input wire logic                   PAD_P_OUT,
   input wire logic                   PAD_P_OE,
   input wire logic                   PAD_N_OUT,
   input wire logic                   PAD_TERM_ENABLE,
   input wire logic [7:0]             HIGHSPEED_RX_WORD,
   input wire logic                   LANE_PARALLEL_CLOCK_OUT,
   input wire logic                   LANE_SERIAL_CLOCK_OUT,
   input wire logic                   CORE_TREE_CLOCK_OUT,
   input wire logic                   RX_TERMINATION_ENABLE,
   input wire logic [7:0]             HIGHSPEED_TX_WORD,
   input wire logic                   HIGHSPEED_DRIVE_ENABLE
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);
   wire logic hs_go = LANE_PARALLEL_CLOCK_OUT && HIGHSPEED_DRIVE_ENABLE
                      && PAD_P_OE && !TX_RESET;
   property p_tx_word;
      logic [7:0] w;
      (hs_go, w = HIGHSPEED_TX_WORD) |=> (!PAD_P_OE || PAD_P_OUT == w[0])
         ##7 (!PAD_P_OE || PAD_P_OUT == w[7]);
   endproperty
   a_strobe_period: assert property (LANE_PARALLEL_CLOCK_OUT |=>
      !LANE_PARALLEL_CLOCK_OUT [*7] ##1 LANE_PARALLEL_CLOCK_OUT)
      else $error("parallel strobe spacing wrong");
   a_tree_duty: assert property ($rose(CORE_TREE_CLOCK_OUT) |=>
      CORE_TREE_CLOCK_OUT [*3] ##1 !CORE_TREE_CLOCK_OUT [*4] ##1
      CORE_TREE_CLOCK_OUT) else $error("tree clock not divide by eight");
   a_serial_running: assert property (LANE_PARALLEL_CLOCK_OUT |->
      LANE_SERIAL_CLOCK_OUT) else $error("serial clock idle");
   a_hs_diff: assert property (HIGHSPEED_DRIVE_ENABLE && PAD_P_OE |->
      PAD_N_OUT == !PAD_P_OUT) else $error("pads not differential");
   a_tx_lsb_order: assert property (p_tx_word)
      else $error("serial bit order wrong");
   a_tx_clear: assert property (LANE_PARALLEL_CLOCK_OUT && TX_RESET &&
      HIGHSPEED_DRIVE_ENABLE && PAD_P_OE |=> !PAD_P_OE || !PAD_P_OUT)
      else $error("serializer not cleared");
   a_term_gate: assert property (PAD_TERM_ENABLE |->
      RX_TERMINATION_ENABLE) else $error("termination without request");
   a_rx_clear: assert property (RX_RESET |=>
      HIGHSPEED_RX_WORD == 8'h00) else $error("receive word not cleared");
   cover property (hs_go);
   cover property ($rose(RX_RESET));
   cover property (PAD_TERM_ENABLE);
endmodule // lane_props
`default_nettype wire

// >>> verification/remote_lane_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Far transmitter: repeating word or levels
// ----------------------------------------
module remote_lane_model (
   input wire logic       clk,
   input wire logic       hs_on,
   input wire logic [7:0] word,
   input wire logic       lp_p,
   input wire logic       lp_n,
   output logic           pad_p,
   output logic           pad_n
);
   logic [2:0] bit_q = 3'h0;
   logic [2:0] bit_d;
   always_comb bit_d = bit_q + 3'h1;
   always_ff @(posedge clk) bit_q <= bit_d;
   assign pad_p = hs_on ? word[bit_q] : lp_p;
   assign pad_n = hs_on ? !word[bit_q] : lp_n;
endmodule // remote_lane_model
`default_nettype wire

// >>> verification/test_dphy_lane_serdes_io.sv
`timescale 1ns/1ps
`default_nettype none
module test_dphy_lane_serdes_io;
   logic clock = 1'b0;
   logic sys_rst, rx_reset, tx_reset, pad_p_in, pad_n_in, far_p, far_n;
   logic pad_p_out, pad_p_oe, pad_n_out, pad_n_oe, term_out;
   logic sense_p, sense_n, q_empty, strobe, ser_clk, tree_clk;
   logic lp_drv_p, lp_drv_n, lp_en_p, lp_en_n, q_rd, buf_en, term_en;
   logic dly_en, dly_dir, dly_clr, hs_drv, hs_on, far_lp_p, far_lp_n;
   logic [7:0] rx_word, tx_word, far_word, r0, b;
   logic [31:0] rd;
   logic [1:0]  rr;
   int          miscompares, checks_done, n;
   lane_pkg::axil_req_type req;
   lane_pkg::axil_rsp_type rsp;
   assign pad_p_in = pad_p_oe ? pad_p_out : far_p;
   assign pad_n_in = pad_n_oe ? pad_n_out : far_n;
   dphy_lane_serdes_io dut_u (.CLOCK(clock), .SYS_RST(sys_rst),
      .AXI_REQ(req), .AXI_RSP(rsp), .RX_RESET(rx_reset),
      .TX_RESET(tx_reset), .PAD_P_IN(pad_p_in), .PAD_N_IN(pad_n_in),
      .PAD_P_OUT(pad_p_out), .PAD_P_OE(pad_p_oe), .PAD_N_OUT(pad_n_out),
      .PAD_N_OE(pad_n_oe), .PAD_TERM_ENABLE(term_out),
      .HIGHSPEED_RX_WORD(rx_word), .LOWPOWER_SENSE_POS(sense_p),
      .LOWPOWER_SENSE_NEG(sense_n), .LOWPOWER_DRIVE_POS(lp_drv_p),
      .LOWPOWER_DRIVE_NEG(lp_drv_n), .LOWPOWER_DRIVE_ENABLE_POS(lp_en_p),
      .LOWPOWER_DRIVE_ENABLE_NEG(lp_en_n), .QUEUE_EMPTY(q_empty),
      .QUEUE_READ_ENABLE(q_rd), .LANE_PARALLEL_CLOCK_OUT(strobe),
      .LANE_SERIAL_CLOCK_OUT(ser_clk), .CORE_TREE_CLOCK_OUT(tree_clk),
      .DIFF_BUFFER_ENABLE(buf_en), .RX_TERMINATION_ENABLE(term_en),
      .DELAY_STEP_ENABLE(dly_en), .DELAY_STEP_DIRECTION(dly_dir),
      .DELAY_COUNTER_CLEAR(dly_clr), .HIGHSPEED_TX_WORD(tx_word),
      .HIGHSPEED_DRIVE_ENABLE(hs_drv));
   remote_lane_model far_u (.clk(clock), .hs_on(hs_on), .word(far_word),
      .lp_p(far_lp_p), .lp_n(far_lp_n), .pad_p(far_p), .pad_n(far_n));
   always #12.5 clock = ~clock;
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clock);
   endtask
   task automatic strobe_wait(input int k);
      repeat (k) do @(posedge clock); while (strobe !== 1'b1);
   endtask
   task automatic axw(input logic [31:0] a, input logic [31:0] d);
      logic da, dw;
      @(posedge clock);
      da = 1'b0;
      dw = 1'b0;
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      while (!(da && dw)) begin
         @(posedge clock);
         if (rsp.awready === 1'b1 && !da) begin
            da = 1'b1;
            req.awvalid <= 1'b0;
         end
         if (rsp.wready === 1'b1 && !dw) begin
            dw = 1'b1;
            req.wvalid <= 1'b0;
         end
      end
      while (rsp.bvalid !== 1'b1) @(posedge clock);
      req.bready <= 1'b0;
      rr = rsp.bresp;
   endtask
   task automatic axr(input logic [31:0] a);
      @(posedge clock);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do @(posedge clock); while (rsp.arready !== 1'b1);
      req.arvalid <= 1'b0;
      do @(posedge clock); while (rsp.rvalid !== 1'b1);
      req.rready <= 1'b0;
      rd = rsp.rdata;
      rr = rsp.rresp;
   endtask
   task automatic dstep(input logic e, input logic d, input logic c);
      strobe_wait(1);
      dly_en <= e;
      dly_dir <= d;
      dly_clr <= c;
      strobe_wait(1);
      dly_en <= 1'b0;
      dly_clr <= 1'b0;
      strobe_wait(3);
      axr(32'h8);
   endtask
   task automatic txword;
      strobe_wait(1);
      for (int i = 0; i < 8; i++) begin
         tick(1);
         b[i] = pad_p_out;
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      axr(32'h0);
      chk(rd, 32'h0);
      axr(32'h10);
      chk(rr, 32'h2);
      chk(rd, 32'h0);
      axw(32'h10, 32'hffffffff);
      chk(rr, 2'h2);
      axr(32'h0);
      chk(rd, 32'h0);
   endtask
   task automatic t_lowpower;
      term_en <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         far_lp_p <= i[0];
         far_lp_n <= i[1];
         tick(2);
         chk({sense_p, sense_n}, {i[0], i[1]});
      end
      chk(term_out, 1'b1);
      axw(32'h0, 32'h4);
      lp_en_p <= 1'b1;
      lp_drv_p <= 1'b1;
      tick(2);
      chk({pad_p_oe, pad_p_out}, 2'h3);
      lp_en_p <= 1'b0;
      axw(32'h0, 32'h0);
   endtask
   task automatic t_rx_delay;
      buf_en <= 1'b1;
      hs_on <= 1'b1;
      far_word <= 8'h01;
      strobe_wait(4);
      r0 = rx_word;
      chk($countones(r0), 1);
      axr(32'h4);
      chk(rd[4], 1'b1);
      dstep(1'b1, 1'b0, 1'b0);
      chk(rd, 32'h0);
      dstep(1'b1, 1'b1, 1'b0);
      chk(rd, 32'h1);
      chk(rx_word, {r0[6:0], r0[7]});
      dstep(1'b1, 1'b1, 1'b0);
      dstep(1'b0, 1'b0, 1'b1);
      chk(rd, 32'h0);
      chk(rx_word, r0);
      axr(32'hc);
      chk(rd, {24'h0, r0});
   endtask
   task automatic t_queue;
      buf_en <= 1'b0;
      axw(32'h0, 32'h1);
      tick(2);
      chk(q_empty, 1'b1);
      buf_en <= 1'b1;
      strobe_wait(7);
      axr(32'h4);
      chk(rd[2:0], 3'h6);
      buf_en <= 1'b0;
      n = 0;
      while (q_empty !== 1'b1 && n < 8) begin
         q_rd <= 1'b1;
         tick(1);
         q_rd <= 1'b0;
         tick(1);
         n++;
      end
      chk(n, 4);
      chk(rx_word, r0);
      buf_en <= 1'b1;
      strobe_wait(3);
      chk(q_empty, 1'b0);
      rx_reset <= 1'b1;
      tick(2);
      chk({q_empty, rx_word}, 9'h100);
      axr(32'h4);
      chk(rd[3], 1'b1);
      rx_reset <= 1'b0;
      buf_en <= 1'b0;
      tick(4);
      axw(32'h4, 32'h4);
      axr(32'h4);
      chk(rd[4:0], 5'h01);
   endtask
   task automatic t_tx;
      hs_on <= 1'b0;
      axw(32'h0, 32'h2);
      tx_word <= 8'h4b;
      hs_drv <= 1'b1;
      txword;
      txword;
      chk(b, 8'h4b);
      chk({pad_p_oe, pad_n_oe}, 2'h3);
      tx_reset <= 1'b1;
      txword;
      txword;
      chk(b, 8'h00);
      tx_reset <= 1'b0;
      hs_drv <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         lp_drv_p <= i[0];
         lp_en_p <= i[1];
         lp_drv_n <= !i[0];
         lp_en_n <= !i[1];
         tick(2);
         chk({pad_p_oe, pad_n_oe, pad_p_oe & pad_p_out,
              pad_n_oe & pad_n_out},
             {i[1], !i[1], i[1] & i[0], !i[1] & !i[0]});
      end
      lp_en_p <= 1'b0;
      lp_en_n <= 1'b0;
      far_lp_p <= 1'b1;
      far_lp_n <= 1'b1;
      tick(2);
      chk({sense_p, sense_n, term_out}, 3'h0);
      axw(32'h0, 32'h6);
      axr(32'h0);
      chk(rd, 32'h6);
      chk({sense_p, sense_n}, 2'h3);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      {rx_reset, tx_reset, lp_drv_p, lp_drv_n, lp_en_p, lp_en_n} = 6'h00;
      {q_rd, buf_en, term_en, dly_en, dly_dir, dly_clr} = 6'h00;
      {hs_drv, hs_on, far_lp_p, far_lp_n, tx_word, far_word} = 20'h0;
      req = '0;
      sys_rst = 1'b1;
      tick(8);
      sys_rst <= 1'b0;
      t_regs;
      t_lowpower;
      t_rx_delay;
      t_queue;
      t_tx;
      results;
   end
   initial begin
      tick(20000);
      miscompares++;
      results;
   end
endmodule // test_dphy_lane_serdes_io
bind dphy_lane_serdes_io lane_props props_u (.CLOCK(CLOCK),
   .SYS_RST(SYS_RST), .RX_RESET(RX_RESET), .TX_RESET(TX_RESET),
   .PAD_P_OUT(PAD_P_OUT), .PAD_P_OE(PAD_P_OE), .PAD_N_OUT(PAD_N_OUT),
   .PAD_TERM_ENABLE(PAD_TERM_ENABLE), .HIGHSPEED_RX_WORD(HIGHSPEED_RX_WORD),
   .LANE_PARALLEL_CLOCK_OUT(LANE_PARALLEL_CLOCK_OUT),
   .LANE_SERIAL_CLOCK_OUT(LANE_SERIAL_CLOCK_OUT),
   .CORE_TREE_CLOCK_OUT(CORE_TREE_CLOCK_OUT),
   .RX_TERMINATION_ENABLE(RX_TERMINATION_ENABLE),
   .HIGHSPEED_TX_WORD(HIGHSPEED_TX_WORD),
   .HIGHSPEED_DRIVE_ENABLE(HIGHSPEED_DRIVE_ENABLE));
`default_nettype wire
